// [design/pfci_host.sv]
// Overview of operation
// - Every non-read order, except a suspend or resume refused with no sector erase running, is issued as its documented address/data write sequence.
// - Reset order writes F0H once, to leave identifier or query mode.
// - Program writes AAH, 55H, A0H, then target address and byte.
// - Erase writes AAH 55H 80H AAH 55H, then 10H at address 0 or 30H at sector.
// - Protect: high voltage on reset pin, write strobe, A6 low, A1 high, A0 low.
// - Unprotect: same pattern with A6 high; sector bits zero.
// - Write cycle: chip enable low, output enable high, write enable low.
// - Read cycle: chip and output enable low, write enable high.
`timescale 1ns/1ps
`default_nettype none
module pfci_host #(
  parameter int ACC_CYC = pfci_pkg::ACCESS_CYC,
  parameter int STB_CYC = pfci_pkg::STROBE_CYC
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire pfci_pkg::pfci_req_t req,
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  output logic                     rsp_query_match,
  output logic                     erase_active,
  output var pfci_pkg::pfci_pins_t pins,
  input  wire logic [7:0]          dq_in
);
  import pfci_pkg::*;

  // Both strobe counts must fit the down-counter
  if (ACC_CYC < 1 || ACC_CYC > (1 << CNT_W) - 1 || STB_CYC < 1 || STB_CYC > (1 << CNT_W) - 1) begin : g_bad_counts
    $error("strobe counts out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WSTB  = 3'b010,
    ST_WGAP  = 3'b011,
    ST_RSTB  = 3'b100,
    ST_FETCH = 3'b101
  } pfci_state_t;

  pfci_state_t       state_ff, nxt_state;
  pfci_req_t         req_ff;
  logic [2:0]        step_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              erase_ff;
  logic              rsp_valid_ff;
  logic [7:0]        rsp_data_ff;
  logic              match_ff;
  logic [20:0]       rom_addr;
  logic [7:0]        rom_data;
  logic [2:0]        rom_len;
  logic [20:0]       wr_addr;
  logic [7:0]        wr_data;
  logic              is_read;
  logic              is_hv;
  logic              cnt_done;
  logic              last_step;
  logic              take;
  logic              op_legal;
  logic [7:0]        expect_byte;
  logic [20:0]       q_off;

  pfci_seq_rom u_rom (
    .clock     (clock),
    .op        (req_ff.op),
    .step      (step_ff),
    .user_addr (req_ff.addr),
    .user_data (req_ff.data),
    .rd_addr   (rom_addr),
    .rd_data   (rom_data),
    .rd_len    (rom_len)
  );

  // -----------------------------------------------------------------
  // Decode
  // -----------------------------------------------------------------
  assign is_read   = (req_ff.op == OP_READ);
  assign is_hv     = (req_ff.op == OP_PROTECT) || (req_ff.op == OP_UNPROTECT);
  assign cnt_done  = (cnt_ff == '0);
  assign last_step = (step_ff == rom_len - 3'h1);
  // Suspend and resume are refused unless a sector erase is running
  assign op_legal  = !((req.op == OP_SUSPEND || req.op == OP_RESUME) && !erase_ff);
  assign req_ready = (state_ff == ST_IDLE);
  assign take      = req_valid && req_ready && op_legal;

  // Protect keeps sector bits, unprotect clears them; A6 selects the kind
  assign wr_addr = (req_ff.op == OP_PROTECT)
                 ? ((req_ff.addr & (~21'h0 << SECT_LSB)) | PROT_LOW_ADDR)
                 : (req_ff.op == OP_UNPROTECT)
                 ? (PROT_LOW_ADDR | (21'h1 << A6_BIT))
                 : rom_addr;
  assign wr_data = is_hv ? req_ff.data : rom_data;

  assign q_off       = req_ff.addr - EXT_QUERY_SIG_FIRST;
  assign expect_byte = (q_off < 21'(EXT_TABLE_LEN)) ? EXT_TABLE[q_off[3:0]] : 8'h00;

  // -----------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // The sequence table answers one cycle late, so writes wait a fetch cycle
      ST_IDLE:  if (take) nxt_state = (req.op == OP_READ) ? ST_SETUP : ST_FETCH;
      ST_FETCH: nxt_state = ST_SETUP;
      ST_SETUP: nxt_state = is_read ? ST_RSTB : ST_WSTB;
      ST_WSTB:  if (cnt_done) nxt_state = ST_WGAP;
      ST_WGAP:  if (cnt_done) nxt_state = (last_step || is_hv) ? ST_IDLE : ST_FETCH;
      ST_RSTB:  if (cnt_done) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
      step_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_SETUP)
        cnt_ff <= is_read ? CNT_W'(ACC_CYC - 1) : CNT_W'(STB_CYC - 1);
      else if (state_ff == ST_WSTB && cnt_done)
        cnt_ff <= CNT_W'(STB_CYC - 1);
      else if (!cnt_done)
        cnt_ff <= cnt_ff - 1'b1;
      if (take)
        step_ff <= '0;
      else if (state_ff == ST_WGAP && cnt_done)
        step_ff <= step_ff + 3'h1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      req_ff <= '0;
    else if (take)
      req_ff <= req;
  end

  // Erase tracking: started by a sector erase, cleared by a device reset order
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      erase_ff <= 1'b0;
    else if (state_ff == ST_WGAP && cnt_done && last_step && req_ff.op == OP_SECT_ERASE)
      erase_ff <= 1'b1;
    else if (state_ff == ST_WGAP && cnt_done && req_ff.op == OP_RESET)
      erase_ff <= 1'b0;
  end
  assign erase_active = erase_ff;

  // -----------------------------------------------------------------
  // Pins
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, high_voltage_level: 1'b0,
                 addr: '0, dq_out: '0, dq_oe: 1'b0};
    end else begin
      pins.rst_n              <= 1'b1;
      pins.high_voltage_level <= is_hv && (nxt_state == ST_WSTB || nxt_state == ST_WGAP);
      pins.ce_n               <= !(nxt_state == ST_WSTB || nxt_state == ST_RSTB);
      pins.we_n               <= !(nxt_state == ST_WSTB);
      pins.oe_n               <= !(nxt_state == ST_RSTB);
      pins.dq_oe              <= (nxt_state == ST_WSTB);
      if (state_ff == ST_SETUP) begin
        pins.addr   <= is_read ? req_ff.addr : wr_addr;
        pins.dq_out <= wr_data;
      end
    end
  end

  // -----------------------------------------------------------------
  // Read answer
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff  <= '0;
      match_ff     <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == ST_RSTB) && cnt_done;
      if (state_ff == ST_RSTB && cnt_done) begin
        rsp_data_ff <= dq_in;
        match_ff    <= (dq_in == expect_byte);
      end
    end
  end
  assign rsp_valid       = rsp_valid_ff;
  assign rsp_data        = rsp_data_ff;
  assign rsp_query_match = match_ff;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  property p_write_strobe;
    @(posedge clock) disable iff (sys_rst)
    !pins.we_n |-> (!pins.ce_n && pins.oe_n && pins.dq_oe);
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("bad write strobe");

  property p_read_strobe;
    @(posedge clock) disable iff (sys_rst)
    !pins.oe_n |-> (!pins.ce_n && pins.we_n && !pins.dq_oe);
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("bad read strobe");

  property p_no_drive_idle;
    @(posedge clock) disable iff (sys_rst)
    pins.we_n |-> !pins.dq_oe;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) else $error("data driven outside write");

  property p_suspend_gate;
    @(posedge clock) disable iff (sys_rst)
    (!pins.we_n && (req_ff.op == OP_SUSPEND || req_ff.op == OP_RESUME)) |-> erase_ff;
  endproperty
  a_suspend_gate: assert property (p_suspend_gate) else $error("suspend without erase");

  property p_hv_only_prot;
    @(posedge clock) disable iff (sys_rst)
    pins.high_voltage_level |-> (is_hv && pins.addr[1:0] == PROT_LOW_ADDR[1:0]);
  endproperty
  a_hv_only_prot: assert property (p_hv_only_prot) else $error("high voltage misuse");

  property p_unprot_a6;
    @(posedge clock) disable iff (sys_rst)
    (pins.high_voltage_level && req_ff.op == OP_UNPROTECT) |-> pins.addr[A6_BIT];
  endproperty
  a_unprot_a6: assert property (p_unprot_a6) else $error("unprotect needs A6 high");

  property p_prog_third;
    @(posedge clock) disable iff (sys_rst)
    (!pins.we_n && req_ff.op == OP_PROGRAM && step_ff == 3'h2) |-> pins.dq_out == CMD_PROGRAM;
  endproperty
  a_prog_third: assert property (p_prog_third) else $error("program setup byte wrong");

  property p_reset_pin;
    @(posedge clock) $fell(sys_rst) |-> !pins.rst_n ##1 pins.rst_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("device reset pin sequence");
endmodule
`default_nettype wire

// [design/pfci_pkg.sv]
package pfci_pkg;
  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;

  // ---------------------------------------------------------------
  // Command bytes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1   = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2   = 8'h55;
  localparam logic [7:0] CMD_AUTOSEL   = 8'h90;
  localparam logic [7:0] CMD_PROGRAM   = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SET = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERS  = 8'h10;
  localparam logic [7:0] CMD_SECT_ERS  = 8'h30;
  localparam logic [7:0] CMD_SUSPEND   = 8'hB0;
  localparam logic [7:0] CMD_RESUME    = 8'h30;
  localparam logic [7:0] CMD_QUERY     = 8'h98;
  localparam logic [7:0] CMD_RESET     = 8'hF0;

  // ---------------------------------------------------------------
  // Identifier-read and query addresses
  // ---------------------------------------------------------------
  localparam logic [20:0] ID_MAKER_ADDR   = 21'h000000;
  localparam logic [20:0] ID_PART_ADDR    = 21'h000001;
  localparam logic [20:0] ID_PROTECT_LOW  = 21'h000002;
  localparam int          SECT_LSB        = 16;
  localparam logic [7:0]  PROTECTED_CODE  = 8'h01;
  localparam logic [7:0]  UNPROTECTED_CODE= 8'h00;

  localparam logic [20:0] EXT_QUERY_SIG_FIRST        = 21'h000040;
  localparam logic [20:0] EXT_QUERY_SIG_SECOND       = 21'h000041;
  localparam logic [20:0] EXT_QUERY_SIG_THIRD        = 21'h000042;
  localparam logic [20:0] EXT_MAJOR_VERSION          = 21'h000043;
  localparam logic [20:0] EXT_MINOR_VERSION          = 21'h000044;
  localparam logic [20:0] UNLOCK_ADDRESS_SENSITIVITY = 21'h000045;
  localparam logic [20:0] SUSPEND_CAPABILITY         = 21'h000046;
  localparam logic [20:0] PROTECT_GROUP_SIZE         = 21'h000047;
  localparam logic [20:0] TEMP_UNPROTECT_SUPPORT     = 21'h000048;
  localparam logic [20:0] PROTECTION_SCHEME_CODE     = 21'h000049;
  localparam logic [20:0] CONCURRENT_RW_SUPPORT      = 21'h00004A;
  localparam logic [20:0] BURST_SUPPORT              = 21'h00004B;
  localparam logic [20:0] PAGE_SUPPORT               = 21'h00004C;
  localparam int          EXT_TABLE_LEN              = 13;

  // Expected contents of the extended table, first entry at 0x40
  localparam logic [7:0] EXT_TABLE [EXT_TABLE_LEN] = '{
    8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01, 8'h02,
    8'h01, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};

  // ---------------------------------------------------------------
  // Protection pin pattern
  // ---------------------------------------------------------------
  localparam int A6_BIT = 6;
  localparam logic [20:0] PROT_LOW_ADDR = 21'h000002;

  // ---------------------------------------------------------------
  // Timing, counted in 25 ns cycles of the 40 MHz clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACCESS_NS     = 100;
  localparam int ACCESS_CYC    = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS     = 50;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;

  // ---------------------------------------------------------------
  // User orders
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_PROGRAM    = 4'h1,
    OP_CHIP_ERASE = 4'h2,
    OP_SECT_ERASE = 4'h3,
    OP_SUSPEND    = 4'h4,
    OP_RESUME     = 4'h5,
    OP_ID_ENTER   = 4'h6,
    OP_QUERY      = 4'h7,
    OP_RESET      = 4'h8,
    OP_PROTECT    = 4'h9,
    OP_UNPROTECT  = 4'hA
  } pfci_op_t;

  typedef struct packed {
    pfci_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } pfci_req_t;

  typedef struct packed {
    logic                ce_n;
    logic                oe_n;
    logic                we_n;
    logic                rst_n;
    logic                high_voltage_level;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dq_out;
    logic                dq_oe;
  } pfci_pins_t;
endpackage

// [design/pfci_seq_rom.sv]
`timescale 1ns/1ps
`default_nettype none
// Sequence table: address/data pair for each write step of an order
module pfci_seq_rom (
  input  wire logic                  clock,
  input  wire pfci_pkg::pfci_op_t    op,
  input  wire logic [2:0]            step,
  input  wire logic [20:0]           user_addr,
  input  wire logic [7:0]            user_data,
  output logic      [20:0]           rd_addr,
  output logic      [7:0]            rd_data,
  output logic      [2:0]            rd_len
);
  import pfci_pkg::*;

  logic [7:0]  sel_data;
  logic [20:0] sel_addr;
  logic [2:0]  sel_len;

  always_comb begin
    sel_addr = '0;
    sel_data = CMD_RESET;
    sel_len  = 3'h1;
    unique case (op)
      OP_PROGRAM: begin
        sel_len = 3'h4;
        unique case (step)
          3'h0:    sel_data = CMD_UNLOCK1;
          3'h1:    sel_data = CMD_UNLOCK2;
          3'h2:    sel_data = CMD_PROGRAM;
          default: begin
            sel_addr = user_addr;
            sel_data = user_data;
          end
        endcase
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        sel_len = 3'h6;
        unique case (step)
          3'h0, 3'h3: sel_data = CMD_UNLOCK1;
          3'h1, 3'h4: sel_data = CMD_UNLOCK2;
          3'h2:       sel_data = CMD_ERASE_SET;
          default: begin
            sel_addr = (op == OP_SECT_ERASE) ? user_addr : '0;
            sel_data = (op == OP_SECT_ERASE) ? CMD_SECT_ERS : CMD_CHIP_ERS;
          end
        endcase
      end
      OP_ID_ENTER: begin
        sel_len = 3'h3;
        unique case (step)
          3'h0:    sel_data = CMD_UNLOCK1;
          3'h1:    sel_data = CMD_UNLOCK2;
          default: sel_data = CMD_AUTOSEL;
        endcase
      end
      OP_SUSPEND: sel_data = CMD_SUSPEND;
      OP_RESUME:  sel_data = CMD_RESUME;
      OP_QUERY:   sel_data = CMD_QUERY;
      default:    sel_data = CMD_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    rd_addr <= sel_addr;
    rd_data <= sel_data;
    rd_len  <= sel_len;
  end
endmodule
`default_nettype wire

// [dv/pfci_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pfci_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h3A, // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h5C  // Arbitrary value
) (
  input  wire pfci_pkg::pfci_pins_t pins,
  output wire logic [7:0]           dq_in,
  output var int                    bad_cycles,
  output var int                    write_count,
  output var logic [1:0]            erase_state
);
  import pfci_pkg::*;
  localparam logic [7:0] QTAB [13] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h30, 8'h01, 8'h02,
    8'h01, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};
  // Mode 0 array read, 1 identifier read, 2 query
  logic [1:0]  mode;
  logic [2:0]  step;
  logic [2:0]  nstep;
  logic [7:0]  mem [int];
  logic [31:0] prot;
  logic [20:0] la;
  logic [7:0]  ld;
  logic [7:0]  last_q;
  logic        lhv;
  wire         wr_act = !pins.ce_n && !pins.we_n;
  wire         rd_act = !pins.ce_n && !pins.oe_n && pins.rst_n;
  wire         in_rst = !pins.rst_n && !pins.high_voltage_level;

  initial begin
    {mode, step, erase_state, prot, last_q} = '0;
    bad_cycles = 0;
    write_count = 0;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_val(input logic [20:0] a);
    if (mode == 2'd2) return (a >= 21'h40 && a <= 21'h4C) ? QTAB[a - 21'h40] : 8'h00;
    if (mode == 2'd1 && a[1:0] == 2'd0) return MAKER_ID;
    if (mode == 2'd1 && a[1:0] == 2'd1) return PART_ID;
    if (mode == 2'd1 && a[1:0] == 2'd2) return {7'h00, prot[a[20:16]]};
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction

  // Released bus shows the inverse of the last byte, never a held value
  assign dq_in = rd_act ? rd_val(pins.addr) : ~last_q;
  always @(pins or rd_act) if (rd_act) last_q = rd_val(pins.addr);

  // ---------------------------------------------------------------
  // Write path
  // ---------------------------------------------------------------
  always @(pins or wr_act) begin
    if (wr_act) begin
      la = pins.addr;
      ld = pins.dq_out;
      lhv = pins.high_voltage_level;
    end
  end

  // Pin fields settle one after another in a time step, so judge them a little later
  always @(pins) begin
    #1;
    if (!pins.ce_n && !pins.we_n && (!pins.oe_n || !pins.dq_oe || in_rst)) bad_cycles++;
    if (pins.dq_oe && (!pins.oe_n || in_rst)) bad_cycles++;
  end

  always @(posedge in_rst) begin
    mode = 2'd0;
    step = 3'd0;
    erase_state = 2'd0;
  end

  always @(negedge wr_act) begin
    if (!in_rst) begin
      write_count++;
      nstep = 3'd0;
      if (lhv) begin
        if (la[1] && !la[0] && !la[6]) prot[la[20:16]] = 1'b1;
        else if (la[1] && !la[0]) prot = '0;
      end
      else if (step == 3'd0 && ld == 8'hAA) nstep = 3'd1;
      else if (step == 3'd0 && ld == 8'hF0) {mode, erase_state} = 4'h0;
      else if (step == 3'd0 && ld == 8'h98) mode = 2'd2;
      else if (step == 3'd0 && ld == 8'hB0 && erase_state == 2'd1) erase_state = 2'd2;
      else if (step == 3'd0 && ld == 8'h30 && erase_state == 2'd2) erase_state = 2'd1;
      else if (step == 3'd1 && ld == 8'h55) nstep = 3'd2;
      else if (step == 3'd2 && ld == 8'h90) mode = 2'd1;
      else if (step == 3'd2 && ld == 8'hA0) nstep = 3'd3;
      else if (step == 3'd2 && ld == 8'h80) nstep = 3'd4;
      else if (step == 3'd3) mem[int'(la)] = ld;
      else if (step == 3'd4 && ld == 8'hAA) nstep = 3'd5;
      else if (step == 3'd5 && ld == 8'h55) nstep = 3'd6;
      else if (step == 3'd6 && ld == 8'h10) mem.delete();
      else if (step == 3'd6 && ld == 8'h30) begin
        foreach (mem[k]) if (k[20:16] == la[20:16]) mem[k] = 8'hFF;
        erase_state = 2'd1;
      end
      else mode = 2'd0;
      step = nstep;
    end
  end
endmodule
`default_nettype wire

// [dv/parallel_flash_command_interface_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_command_interface_tb;
  import pfci_pkg::*;
  localparam logic [7:0] MK = 8'h3A; // Arbitrary value
  localparam logic [7:0] PT = 8'h5C; // Arbitrary value
  logic       clock, sys_rst, req_valid, req_ready, rsp_valid, rsp_query_match, erase_active;
  logic [7:0] rsp_data, dq_in;
  logic [1:0] erase_state;
  pfci_req_t  req;
  pfci_pins_t pins;
  int         miscompares, checked, bad_cycles, write_count, wc;

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  pfci_host uut (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_query_match(rsp_query_match),
    .erase_active(erase_active), .pins(pins), .dq_in(dq_in));
  pfci_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) fm (.pins(pins), .dq_in(dq_in),
    .bad_cycles(bad_cycles), .write_count(write_count), .erase_state(erase_state));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic order(input pfci_op_t op, input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    req <= '{op, a, d};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (op != OP_READ && req_ready !== 1'b1 && n < 500);
  endtask

  task automatic rd(input logic [20:0] a, input logic [7:0] exp, input string what);
    int n;
    n = 0;
    order(OP_READ, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 100) begin
      @(posedge clock);
      n++;
    end
    check8("read answer", 8'h01, {7'h00, rsp_valid});
    check8(what, exp, rsp_data);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    miscompares = 0;
    checked = 0;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rd(21'h001234, 8'hFF, "blank");
    order(OP_PROGRAM, 21'h001234, 8'hA5);
    rd(21'h001234, 8'hA5, "programmed");
    order(OP_ID_ENTER, 21'h0, 8'h00);
    rd(21'h1ABCD4, MK, "maker id");
    rd(21'h1ABCD5, PT, "part id");
    rd(21'h030002, 8'h00, "unprotected");
    order(OP_RESET, 21'h0, 8'h00);
    rd(21'h001234, 8'hA5, "array after id");
    order(OP_PROTECT, 21'h030000, 8'h00);
    order(OP_ID_ENTER, 21'h0, 8'h00);
    rd(21'h030002, 8'h01, "protected");
    rd(21'h040002, 8'h00, "other sector");
    order(OP_RESET, 21'h0, 8'h00);
    order(OP_UNPROTECT, 21'h030000, 8'h00);
    order(OP_ID_ENTER, 21'h0, 8'h00);
    rd(21'h030002, 8'h00, "unprotect");
    order(OP_RESET, 21'h0, 8'h00);
    order(OP_QUERY, 21'h0, 8'h00);
    for (int i = 0; i < 14; i++) begin
      rd(21'h40 + 21'(i % 13), EXT_TABLE[i % 13], "query");
      check8("query match", 8'h01, {7'h00, rsp_query_match});
    end
    order(OP_RESET, 21'h0, 8'h00);
    rd(21'h001234, 8'hA5, "array after query");
    order(OP_CHIP_ERASE, 21'h0, 8'h00);
    rd(21'h001234, 8'hFF, "chip erased");
    wc = write_count;
    @(posedge clock);
    req <= '{OP_SUSPEND, 21'h0, 8'h00};
    req_valid <= 1'b1;
    repeat (4) @(posedge clock);
    check8("ready on idle suspend", 8'h01, {7'h00, req_ready});
    req_valid <= 1'b0;
    repeat (10) @(posedge clock);
    check8("idle suspend writes", 8'h01, {7'h00, write_count == wc});
    order(OP_PROGRAM, 21'h050010, 8'h3C);
    order(OP_PROGRAM, 21'h060010, 8'hC3);
    order(OP_SECT_ERASE, 21'h050000, 8'h00);
    rd(21'h050010, 8'hFF, "sector erased");
    rd(21'h060010, 8'hC3, "sector kept");
    check8("erase active", 8'h01, {7'h00, erase_active});
    order(OP_SUSPEND, 21'h0, 8'h00);
    check8("suspended", 8'h02, {6'h00, erase_state});
    order(OP_RESUME, 21'h0, 8'h00);
    check8("resumed", 8'h01, {6'h00, erase_state});
    order(OP_RESET, 21'h0, 8'h00);
    order(OP_QUERY, 21'h0, 8'h00);
    check8("erase cleared", 8'h00, {7'h00, erase_active});
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(21'h000040, 8'hFF, "array after pin reset");
    check8("match off table", 8'h00, {7'h00, rsp_query_match});
    check8("pin faults", 8'h01, {7'h00, bad_cycles == 0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
